// ---- pdslc_pkg.sv ----
// package: offsets, field layouts and reset values of the port error status and link capability registers
package pdslc_pkg;

  localparam logic [7:0] PDSLC_OFS_ERR_STATUS = 8'hC8;
  localparam logic [7:0] PDSLC_OFS_LINK_CAP   = 8'hCC;

  // bit positions in the status word (upper half of the dword at C8h)
  localparam int PDSLC_BIT_CORR   = 16;
  localparam int PDSLC_BIT_NFATAL = 17;
  localparam int PDSLC_BIT_FATAL  = 18;
  localparam int PDSLC_BIT_UNSUP  = 19;
  localparam int PDSLC_BIT_AUXPWR = 20;
  localparam int PDSLC_BIT_TPEND  = 21;

  localparam logic [3:0] PDSLC_SPEED_2G5   = 4'h1;
  localparam logic [3:0] PDSLC_SPEED_5G0   = 4'h2;
  localparam logic [3:0] PDSLC_RST_SPEED   = PDSLC_SPEED_5G0;
  localparam logic [5:0] PDSLC_RST_WIDTH   = 6'h04;
  localparam logic [1:0] PDSLC_RST_ASPM    = 2'h0;
  localparam logic [2:0] PDSLC_RST_L0S_LAT = 3'h3;
  localparam logic [2:0] PDSLC_RST_L1_LAT  = 3'h0;
  localparam logic       PDSLC_RST_AUXPWR  = 1'b1;
  localparam logic       PDSLC_RST_CLKPM_UP   = 1'b1;
  localparam logic       PDSLC_RST_DLACT_DN   = 1'b1;
  localparam logic       PDSLC_RST_SDOWN      = 1'b0;
  localparam logic       PDSLC_RST_BWNOTE     = 1'b0;
  localparam logic [1:0] PDSLC_UPSTREAM_PORT  = 2'h0;

  // field positions in the link capability word
  localparam int PDSLC_CAP_SPEED_LO = 0;
  localparam int PDSLC_CAP_SPEED_HI = 3;
  localparam int PDSLC_CAP_WIDTH_LO = 4;
  localparam int PDSLC_CAP_WIDTH_HI = 9;
  localparam int PDSLC_CAP_ASPM_LO  = 10;
  localparam int PDSLC_CAP_ASPM_HI  = 11;
  localparam int PDSLC_CAP_L0S_LO   = 12;
  localparam int PDSLC_CAP_L0S_HI   = 14;
  localparam int PDSLC_CAP_L1_LO    = 15;
  localparam int PDSLC_CAP_L1_HI    = 17;
  localparam int PDSLC_CAP_CLKPM    = 18;
  localparam int PDSLC_CAP_SDOWN    = 19;
  localparam int PDSLC_CAP_DLACT    = 20;
  localparam int PDSLC_CAP_BWNOTE   = 21;
  localparam int PDSLC_CAP_PORT_LO  = 24;
  localparam int PDSLC_CAP_PORT_HI  = 31;

  // loadable capability fields
  typedef struct packed {
    logic [7:0] port_num;
    logic       bw_notify;
    logic       surprise_down;
    logic       clk_pm;
    logic [2:0] l1_lat;
    logic [2:0] l0s_lat;
    logic [1:0] aspm;
  } pdslc_cap_s;

  // error detect pulses
  typedef struct packed {
    logic unsup;
    logic fatal;
    logic nfatal;
    logic corr;
  } pdslc_err_s;

  typedef enum logic [1:0] {
    PDSLC_IDLE,
    PDSLC_LOADED
  } pdslc_ld_e;

  function automatic pdslc_cap_s pdslc_cap_default(input logic [1:0] port);
    pdslc_cap_s c;
    c.port_num      = {6'h00, port};
    c.bw_notify     = PDSLC_RST_BWNOTE;
    c.surprise_down = PDSLC_RST_SDOWN;
    c.clk_pm        = (port == PDSLC_UPSTREAM_PORT) ? PDSLC_RST_CLKPM_UP : 1'b0;
    c.l1_lat        = PDSLC_RST_L1_LAT;
    c.l0s_lat       = PDSLC_RST_L0S_LAT;
    c.aspm          = PDSLC_RST_ASPM;
    return c;
  endfunction

endpackage

// ---- pdslc_err_flags.sv ----
// sticky write-one-to-clear error detected flags
`timescale 1ns/1ns
module pdslc_err_flags
  import pdslc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire pdslc_err_s err_det,
  input  wire logic       clr_we,
  input  wire logic [3:0] clr_mask,
  output logic      [3:0] flags_q
);

  logic [3:0] flags_d;

  // set wins over a clear in the same cycle; reporting enables are not consulted
  always_comb begin
    flags_d = (flags_q & ~(clr_we ? clr_mask : 4'h0)) | err_det;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// ---- pdslc_regs.sv ----
// port error status and link capability configuration registers
//
// Contract
// - correctable error sets sticky flag, write-one clears
// - non-fatal error sets sticky flag, write-one clears
// - fatal error sets sticky flag, write-one clears
// - unsupported request sets sticky flag, write-one clears
// - flags logged regardless of reporting enables
// - aux power detected bit, read-only, resets one
// - transactions pending bit always zero
// - max link speed field, resets to 5.0G
// - max link width field resets to x4
// - ASPM support field read-only, resets zero
// - L0s exit latency field resets 011b
// - L1 exit latency field resets 000b
// - upstream clock PM capability resets one
// - downstream clock PM capability tied zero
// - DL active reporting: upstream zero, downstream one
// - bandwidth notification capability resets zero
// - port number resets to own port index
// - loadable fields take externally loaded values, except clock PM on downstream ports, which stays zero
`timescale 1ns/1ns
module pdslc_regs
  import pdslc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [1:0]  port_id,
  input  wire logic        aux_power,
  input  wire pdslc_err_s  err_det,
  input  wire logic        cfg_load,
  input  wire pdslc_cap_s  cfg_load_data,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic      [31:0] cfg_rdata_q,
  output logic             cfg_rvalid_q,
  output logic      [3:0]  err_flags_q
);

  logic [3:0]  flags;
  logic        clr_we;
  logic [3:0]  clr_mask;
  logic        is_up;
  logic        aux_q;
  logic        aux_d;
  pdslc_cap_s  cap_q;
  pdslc_cap_s  cap_d;
  pdslc_ld_e   ld_q;
  pdslc_ld_e   ld_d;
  logic [31:0] status_word;
  logic [31:0] cap_word;
  logic [31:0] rdata_d;
  logic        rvalid_d;
  logic        rst_seen_q;
  logic        rst_seen_d;
  pdslc_cap_s  cap_eff;
  logic        sts_hit;
  logic        cap_hit;

  // address decode shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
    return (addr == ofs);
  endfunction

  // downstream ports never advertise clock power management, whatever a loader supplies
  function automatic pdslc_cap_s port_fix(input pdslc_cap_s c,
                                          input logic       up);
    pdslc_cap_s f;
    f = c;
    if (!up) begin
      f.clk_pm = 1'b0;
    end
    return f;
  endfunction

  // reserved bits and the pending bit always read zero
  function automatic logic [31:0] pack_status(input logic [3:0] fl,
                                              input logic       aux);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PDSLC_BIT_UNSUP:PDSLC_BIT_CORR] = fl;
    w[PDSLC_BIT_AUXPWR]               = aux;
    w[PDSLC_BIT_TPEND]                = 1'b0;
    return w;
  endfunction

  // fields that are not loadable come straight from the package constants
  function automatic logic [31:0] pack_cap(input pdslc_cap_s c,
                                           input logic       up);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PDSLC_CAP_SPEED_HI:PDSLC_CAP_SPEED_LO] = PDSLC_RST_SPEED;
    w[PDSLC_CAP_WIDTH_HI:PDSLC_CAP_WIDTH_LO] = PDSLC_RST_WIDTH;
    w[PDSLC_CAP_ASPM_HI:PDSLC_CAP_ASPM_LO]   = c.aspm;
    w[PDSLC_CAP_L0S_HI:PDSLC_CAP_L0S_LO]     = c.l0s_lat;
    w[PDSLC_CAP_L1_HI:PDSLC_CAP_L1_LO]       = c.l1_lat;
    w[PDSLC_CAP_CLKPM]                       = c.clk_pm;
    w[PDSLC_CAP_SDOWN]                       = c.surprise_down;
    w[PDSLC_CAP_DLACT]                       = up ? 1'b0 : PDSLC_RST_DLACT_DN;
    w[PDSLC_CAP_BWNOTE]                      = c.bw_notify;
    w[PDSLC_CAP_PORT_HI:PDSLC_CAP_PORT_LO]   = c.port_num;
    return w;
  endfunction

  assign is_up = (port_id == PDSLC_UPSTREAM_PORT);

  // one decode serves both paths, so a write and a read never disagree on the target
  always_comb begin
    sts_hit = addr_hit(cfg_addr, PDSLC_OFS_ERR_STATUS);
    cap_hit = addr_hit(cfg_addr, PDSLC_OFS_LINK_CAP);
  end

  // only byte lane 2 carries the flag bits; other fields ignore writes
  always_comb begin
    clr_we   = cfg_wr && sts_hit && cfg_be[2];
    clr_mask = cfg_wdata[PDSLC_BIT_UNSUP:PDSLC_BIT_CORR];
  end

  pdslc_err_flags u_flags (
    .mclk     (mclk),
    .reset    (reset),
    .err_det  (err_det),
    .clr_we   (clr_we),
    .clr_mask (clr_mask),
    .flags_q  (flags)
  );

  // capability defaults follow the port at reset; a loader may then overwrite them
  always_comb begin
    cap_d = cap_q;
    ld_d  = ld_q;
    aux_d = aux_power;
    // the first cycle out of reset takes this port's own defaults
    if (!rst_seen_q) begin
      cap_d = pdslc_cap_default(port_id);
    end
    case (ld_q)
      PDSLC_IDLE: begin
        if (cfg_load) begin
          cap_d = cfg_load_data;
          ld_d  = PDSLC_LOADED;
        end
      end
      PDSLC_LOADED: begin
        // later loads still allowed, e.g. from a second source
        if (cfg_load) begin
          cap_d = cfg_load_data;
        end
      end
      default: begin
        ld_d = PDSLC_IDLE;
      end
    endcase
    cap_d = port_fix(cap_d, is_up);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cap_q <= pdslc_cap_default(2'h0);
      ld_q  <= PDSLC_IDLE;
      aux_q <= PDSLC_RST_AUXPWR;
    end else begin
      cap_q <= cap_d;
      ld_q  <= ld_d;
      aux_q <= aux_d;
    end
  end

  // until the first edge out of reset the register still holds port 0 defaults
  always_comb begin
    rst_seen_d = 1'b1;
    cap_eff    = port_fix(rst_seen_q ? cap_q : pdslc_cap_default(port_id), is_up);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rst_seen_q <= 1'b0;
    end else begin
      rst_seen_q <= rst_seen_d;
    end
  end

  always_comb begin
    status_word = pack_status(flags, aux_q);
    cap_word    = pack_cap(cap_eff, is_up);
  end

  always_comb begin
    rdata_d  = 32'h0000_0000;
    rvalid_d = cfg_rd;
    if (cfg_rd) begin
      // unmapped offsets keep the zero default but are still answered
      if (sts_hit) begin
        rdata_d = status_word;
      end else if (cap_hit) begin
        rdata_d = cap_word;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
      err_flags_q  <= 4'h0;
    end else begin
      cfg_rdata_q  <= rdata_d;
      cfg_rvalid_q <= rvalid_d;
      err_flags_q  <= flags;
    end
  end

endmodule

// ---- pdslc_regs_assertions.sv ----
// checker: answer timing and field relations of the port registers
`timescale 1ns/1ns
module pdslc_regs_chk
  import pdslc_pkg::*;
(
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic [1:0]  port_id,
  input wire logic        aux_power,
  input wire pdslc_err_s  err_det,
  input wire logic        cfg_load,
  input wire pdslc_cap_s  cfg_load_data,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_rvalid_q,
  input wire logic [3:0]  err_flags_q
);
  localparam logic [7:0] STS = PDSLC_OFS_ERR_STATUS;
  localparam logic [7:0] CAP = PDSLC_OFS_LINK_CAP;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_rv; cfg_rd |=> cfg_rvalid_q; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_cap; cfg_rd && cfg_addr == CAP |=> cfg_rdata_q[9:0] == 10'h042 && cfg_rdata_q[23:22] == 2'h0; endproperty
  a_cap: assert property (p_cap) else $error("speed or width wrong");
  property p_dl; cfg_rd && cfg_addr == CAP |=> cfg_rdata_q[20] == (port_id != 2'h0)
    && !(cfg_rdata_q[18] && port_id != 2'h0); endproperty
  a_dl: assert property (p_dl) else $error("port dependent bit wrong");
  property p_sts; cfg_rd && cfg_addr == STS |=> {cfg_rdata_q[31:21], cfg_rdata_q[15:0]} == 27'h0
    && cfg_rdata_q[19:16] == err_flags_q; endproperty
  a_sts: assert property (p_sts) else $error("status word wrong");
  property p_aux; cfg_rd && cfg_addr == STS && !$past(reset) |=> cfg_rdata_q[20] == $past(aux_power, 2); endproperty
  a_aux: assert property (p_aux) else $error("aux bit wrong");
  property p_set; err_det != 4'h0 |-> ##2 (err_flags_q & $past(err_det, 2)) == $past(err_det, 2); endproperty
  a_set: assert property (p_set) else $error("error not logged");
  property p_clr; |($past(err_flags_q) & ~err_flags_q) |-> $past(cfg_wr, 2) && $past(cfg_be[2], 2)
    && $past(cfg_addr, 2) == STS; endproperty
  a_clr: assert property (p_clr) else $error("flag lost");
  property p_rise; |(err_flags_q & ~$past(err_flags_q)) |-> $past(err_det, 2) != 4'h0; endproperty
  a_rise: assert property (p_rise) else $error("flag set by itself");
endmodule
bind pdslc_regs pdslc_regs_chk u_chk (.mclk, .reset, .port_id, .aux_power, .err_det, .cfg_load, .cfg_load_data,
  .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata_q, .cfg_rvalid_q, .err_flags_q);

// ---- pdslc_regs_tb.sv ----
// testbench: error logging, clears, loads and reads on each of the three ports
`timescale 1ns/1ns
module pdslc_regs_tb;
  import pdslc_pkg::*;
  localparam logic [7:0] STS = PDSLC_OFS_ERR_STATUS;
  localparam logic [7:0] CAP = PDSLC_OFS_LINK_CAP;
  logic        mclk = 0, reset = 1, aux_power = 1, cfg_load = 0, cfg_wr = 0, cfg_rd = 0, cfg_rvalid_q;
  logic [1:0]  port_id = 0;
  logic [7:0]  cfg_addr = 0;
  logic [31:0] cfg_wdata = 0, cfg_rdata_q;
  logic [3:0]  cfg_be = 0, err_flags_q, m;
  pdslc_err_s  err_det = '0;
  pdslc_cap_s  cfg_load_data = '0, cap;
  int          n_fail = 0, n_compared = 0;
  always #4 mclk = ~mclk;
  pdslc_regs u_dut (.mclk, .reset, .port_id, .aux_power, .err_det, .cfg_load, .cfg_load_data,
    .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_rdata_q, .cfg_rvalid_q, .err_flags_q);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // downstream ports never offer clock removal, whatever was loaded
  function automatic logic [31:0] capw();
    return {cap.port_num, 2'h0, cap.bw_notify, port_id != 2'h0, cap.surprise_down,
      cap.clk_pm & (port_id == 2'h0), cap.l1_lat, cap.l0s_lat, cap.aspm, 6'h04, 4'h2};
  endfunction
  function automatic logic [31:0] stsw();
    return {11'h000, aux_power, m, 16'h0000};
  endfunction
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    cfg_rd <= 1;
    cfg_addr <= a;
    @(posedge mclk);
    cfg_rd <= 0;
    #1;
    chk({31'h0, cfg_rvalid_q}, 32'h1);
    chk(cfg_rdata_q, x);
  endtask
  // a set in the same cycle as its clear must survive
  task automatic op(input logic [3:0] ev, cm, be, input logic [7:0] a);
    @(posedge mclk);
    err_det <= ev;
    aux_power <= ev[0];
    cfg_wr <= 1;
    cfg_addr <= a;
    cfg_wdata <= {12'h000, cm, 16'h0000};
    cfg_be <= be;
    @(posedge mclk);
    err_det <= '0;
    cfg_wr <= 0;
    m = (m & ~((a == STS && be[2]) ? cm : 4'h0)) | ev;
  endtask
  initial begin
    void'($urandom(30863));
    for (int p = 0; p < 3; p++) begin
      @(posedge mclk);
      reset <= 1;
      port_id <= 2'(p);
      m = 4'h0;
      repeat (5) @(posedge mclk);
      reset <= 0;
      cap = {6'h00, 2'(p), 3'h1, 3'h0, 3'h3, 2'h0};
      rd(CAP, capw());
      rd(STS, stsw());
      op(4'hF, 4'hF, 4'hB, STS);
      op(4'h0, 4'hF, 4'hF, CAP);
      rd(STS, stsw());
      op(4'h1, 4'h1, 4'h4, STS);
      op(4'h0, 4'h6, 4'h4, STS);
      rd(STS, stsw());
      rd(CAP, capw());
      repeat (20) begin
        op(4'($urandom), 4'($urandom), 4'($urandom), $urandom_range(1) ? STS : CAP);
        rd(STS, stsw());
        chk({28'h0, err_flags_q}, {28'h0, m});
      end
      cap = 19'($urandom);
      @(posedge mclk);
      cfg_load <= 1;
      cfg_load_data <= cap;
      @(posedge mclk);
      cfg_load <= 0;
      rd(CAP, capw());
      rd(8'hD0, 32'h0);
    end
    test_done();
  end
endmodule
